// *** shared/asa_pkg.sv ***
// Constants for the acquisition sync and stream allocator
//
// Notes on behaviour
// - Oversample clock derives from backplane reference clock.
// - Sync master drives one pulse on selected line.
// - Sync pulse resets converters and oversample divider.
// - Sync slaves take pulse from master's line.
// - Start master sends start; slaves start on it.
// - Data valid only after filter group delay.
// - Four timing engines, one task each.
// - Each engine keeps its own sample mode.
// - Four streams per type, eight channels each.
// - Four banks of eight, one mode each.
// - Claimed channel forces whole bank mode.
// - Stream takes any channels of matching mode.
// - Channel already allocated is refused with error.
// - Bank mode conflict is refused with error.
// - All engines busy: task refused with error.
// - Too few free streams: task refused.
// - Accessory presence, identity readable by software.
// - Reference locked to backplane or free-running.
// - Start honoured only after group delay from sync.
package asa_pkg;
  localparam int unsigned NCH      = 32;
  localparam int unsigned NBANK    = 4;
  localparam int unsigned NENG     = 4;
  localparam int unsigned NTRIG    = 8;
  localparam int unsigned CLK_MHZ  = 100;
  // Own choice of pulse width on the trigger line
  localparam int unsigned SYNC_PULSE_NS  = 80;
  localparam int unsigned SYNC_PULSE_CYC = (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_MINDL = 8'h08;
  localparam logic [7:0] OFS_GDLY  = 8'h0C;
  localparam logic [7:0] OFS_TMASK = 8'h10;
  localparam logic [7:0] OFS_TCMD  = 8'h14;
  localparam logic [7:0] OFS_ALLOC = 8'h18;
  localparam logic [7:0] OFS_CBUSY = 8'h1C;
  localparam logic [7:0] OFS_ACC   = 8'h20;
  // Control fields
  localparam int unsigned CB_REFSEL = 0;
  localparam int unsigned CB_SMAST  = 1;
  localparam int unsigned CB_TMAST  = 2;
  localparam int unsigned CB_SARM   = 3;
  localparam int unsigned CB_TARM   = 4;
  localparam int unsigned CB_STOP   = 5;
  localparam int unsigned CF_SLINE  = 8;
  localparam int unsigned CF_TLINE  = 12;
  // Status fields
  localparam int unsigned SB_ERR    = 4;
  localparam int unsigned SF_ECODE  = 8;
  localparam int unsigned SB_ACCCHG = 13;
  // Task command fields
  localparam int unsigned TB_MODE   = 0;
  localparam int unsigned TB_ALLOC  = 1;
  localparam int unsigned TB_FREE   = 2;
  localparam int unsigned TF_ENG    = 4;
  // Reset values
  localparam logic [15:0] CTRL_RST  = 16'h0001;
  localparam logic [23:0] GDLY_RST  = 24'h000400;
  localparam logic [23:0] MINDL_RST = 24'h000000;
  localparam logic        MODE_BUF  = 1'b0;
  localparam logic        MODE_HW   = 1'b1;
  typedef enum logic [2:0] {ERR_NONE, ERR_EMPTY, ERR_ENGINE, ERR_CHAN, ERR_MODE,
                            ERR_STREAM} asa_err_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SWAIT, ST_SPULSE, ST_SETTLE, ST_TWAIT,
                            ST_TPULSE, ST_RUN} asa_state_t;
endpackage : asa_pkg

// *** src/asa_sync_alloc.sv ***
// Sync, start and stream allocation logic of the acquisition module
`timescale 1ns/1ps
`default_nettype none
module asa_sync_alloc #(
  parameter int unsigned OS_DIV = 4
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // APB slave
  input  wire logic [7:0]                  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Backplane reference and trigger lines
  input  wire logic                        ref_clk_in,
  input  wire logic [asa_pkg::NTRIG-1:0]   trig_in,
  output logic      [asa_pkg::NTRIG-1:0]   trig_out,
  output logic      [asa_pkg::NTRIG-1:0]   trig_oe_n,
  // Converter side
  output logic                             adc_sync_rst,
  output logic                             os_clk_out,
  output logic      [asa_pkg::NBANK-1:0]   adc_bank_mode,
  output logic                             acq_start,
  output logic                             data_ready,
  output logic      [asa_pkg::NENG-1:0]    eng_busy,
  // Accessory power and comm pins
  input  wire logic                        acc_detect_n,
  input  wire logic                        acc_data_in,
  output logic                             acc_pwr_en,
  output logic                             acc_clk_out,
  output logic                             acc_data_out,
  output logic                             acc_data_oe_n
);
  import asa_pkg::*;

  localparam int NPIN = NTRIG + 3;
  localparam int PREF = NTRIG;
  localparam int PDET = NTRIG + 1;
  localparam int PDIN = NTRIG + 2;
  // Detect pin idles high; chains start there so reset makes no false edge
  localparam logic [NPIN-1:0] PIN_IDLE = {1'b0, 1'b1, {(NPIN-2){1'b0}}};

  // Pin synchronisers; change counts once stages two and three agree
  logic [NPIN-1:0] pin_in, s1_r, s2_r, s3_r, filt_r, filt_nxt, rise;
  assign pin_in = {acc_data_in, acc_detect_n, ref_clk_in, trig_in};
  always_comb
  begin
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
    rise     = filt_nxt & ~filt_r;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r   <= PIN_IDLE;
      s2_r   <= PIN_IDLE;
      s3_r   <= PIN_IDLE;
      filt_r <= PIN_IDLE;
    end
    else
    begin
      s1_r   <= pin_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // Register and allocation state
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [23:0] mindl_r, mindl_nxt, gdly_r, gdly_nxt;
  logic [31:0] tmask_r, tmask_nxt, prdata_r, prdata_nxt;
  logic        tmode_r, tmode_nxt, pslverr_r, pslverr_nxt, err_r, err_nxt;
  logic        accchg_r, accchg_nxt;
  asa_err_t    ecode_r, ecode_nxt;
  logic [1:0]  leng_r, leng_nxt;
  logic [3:0]  acc_r, acc_nxt, bmode_r, bmode_nxt;
  logic [NENG-1:0] busy_r, busy_nxt, emode_r, emode_nxt;
  logic [31:0] emask_r [NENG];
  logic [31:0] emask_nxt [NENG];
  logic [2:0]  estrm_r [NENG];
  logic [2:0]  estrm_nxt [NENG];
  asa_state_t  st_r;

  logic        wr, rd_setup, mapped, sarm_p, tarm_p, stop_p, alloc_p, free_p, cmode;
  logic [31:0] cbusy, rdata;
  logic [NBANK-1:0] bused, breq, bconf;
  logic [5:0]  pc;
  logic [2:0]  need, used_buf, used_hw;
  logic        eng_free;
  logic [1:0]  feng;
  asa_err_t    rej;

  assign pready   = 1'b1;
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign cmode    = pwdata[TB_MODE];
  assign sarm_p   = wr && paddr == OFS_CTRL && pwdata[CB_SARM];
  assign tarm_p   = wr && paddr == OFS_CTRL && pwdata[CB_TARM];
  assign stop_p   = wr && paddr == OFS_CTRL && pwdata[CB_STOP];
  assign alloc_p  = wr && paddr == OFS_TCMD && pwdata[TB_ALLOC];
  assign free_p   = wr && paddr == OFS_TCMD && pwdata[TB_FREE];

  // One mode per bank of eight converters
  for (genvar b = 0; b < NBANK; b++)
  begin : g_bank
    assign bused[b] = |cbusy[8*b +: 8];
    assign breq[b]  = |tmask_r[8*b +: 8];
    assign bconf[b] = breq[b] & bused[b] & (bmode_r[b] != cmode);
  end

  always_comb
  begin
    cbusy    = '0;
    used_buf = '0;
    used_hw  = '0;
    pc       = '0;
    eng_free = 1'b0;
    feng     = '0;
    for (int e = 0; e < NENG; e++)
    begin
      if (busy_r[e])
      begin
        cbusy = cbusy | emask_r[e];
        if (emode_r[e] == MODE_HW)
          used_hw = used_hw + estrm_r[e];
        else
          used_buf = used_buf + estrm_r[e];
      end
    end
    for (int e = NENG - 1; e >= 0; e--)
    begin
      if (!busy_r[e])
      begin
        eng_free = 1'b1;
        feng     = 2'(e);
      end
    end
    for (int c = 0; c < NCH; c++)
      pc = pc + 6'(tmask_r[c]);
    need = 3'((pc + 6'd7) >> 3);
    // Refusal priority: empty, engines, channel, bank mode, streams
    if (pc == '0)
      rej = ERR_EMPTY;
    else if (!eng_free)
      rej = ERR_ENGINE;
    else if ((tmask_r & cbusy) != '0)
      rej = ERR_CHAN;
    else if (bconf != '0)
      rej = ERR_MODE;
    else if (need > 3'(4) - (cmode ? used_hw : used_buf))
      rej = ERR_STREAM;
    else
      rej = ERR_NONE;
  end

  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    mindl_nxt = mindl_r;
    gdly_nxt  = gdly_r;
    tmask_nxt = tmask_r;
    tmode_nxt = tmode_r;
    leng_nxt  = leng_r;
    acc_nxt   = acc_r;
    busy_nxt  = busy_r;
    emode_nxt = emode_r;
    bmode_nxt = bmode_r;
    emask_nxt = emask_r;
    estrm_nxt = estrm_r;
    ecode_nxt = ecode_r;
    err_nxt   = err_r;
    accchg_nxt = accchg_r;
    if (wr && paddr == OFS_STAT && pwdata[SB_ERR])
      err_nxt = 1'b0;
    if (wr && paddr == OFS_STAT && pwdata[SB_ACCCHG])
      accchg_nxt = 1'b0;
    if (wr)
    begin
      unique case (paddr)
        OFS_CTRL:  ctrl_nxt  = pwdata[15:0] & 16'h77C7;
        OFS_MINDL: mindl_nxt = pwdata[23:0];
        OFS_GDLY:  gdly_nxt  = pwdata[23:0];
        OFS_TMASK: tmask_nxt = pwdata;
        OFS_ACC:   acc_nxt   = pwdata[3:0];
        default: ;
      endcase
    end
    if (free_p)
      busy_nxt[pwdata[TF_ENG +: 2]] = 1'b0;
    if (alloc_p)
    begin
      tmode_nxt = cmode;
      if (rej != ERR_NONE)
      begin
        err_nxt   = 1'b1;
        ecode_nxt = rej;
      end
      else
      begin
        busy_nxt[feng]  = 1'b1;
        emode_nxt[feng] = cmode;
        emask_nxt[feng] = tmask_r;
        estrm_nxt[feng] = need;
        leng_nxt        = feng;
        for (int b = 0; b < NBANK; b++)
          if (breq[b])
            bmode_nxt[b] = cmode;
      end
    end
    if (rise[PDET] || (filt_nxt[PDET] && !filt_r[PDET]) == 1'b0 && filt_r[PDET]
        && !filt_nxt[PDET])
      accchg_nxt = 1'b1;
    mapped = paddr[1:0] == 2'b00 && paddr <= OFS_ACC;
    unique case (paddr)
      OFS_CTRL:  rdata = {16'h0, ctrl_r};
      OFS_STAT:  rdata = {13'h0, st_r, 2'b0, accchg_r, ~filt_r[PDET], 1'b0,
                          ecode_r, 3'b0, err_r, 1'b0, data_ready,
                          st_r == ST_RUN, st_r >= ST_SETTLE};
      OFS_MINDL: rdata = {8'h0, mindl_r};
      OFS_GDLY:  rdata = {8'h0, gdly_r};
      OFS_TMASK: rdata = tmask_r;
      OFS_TCMD:  rdata = {26'h0, leng_r, 3'b0, tmode_r};
      OFS_ALLOC: rdata = {13'h0, used_hw, 1'b0, used_buf, bmode_r, bused, busy_r};
      OFS_CBUSY: rdata = cbusy;
      OFS_ACC:   rdata = {26'h0, filt_r[PDIN], ~filt_r[PDET], acc_r};
      default:   rdata = 32'h0;
    endcase
    prdata_nxt  = rd_setup && !pwrite ? rdata : prdata_r;
    pslverr_nxt = rd_setup ? !mapped : pslverr_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r    <= CTRL_RST;
      mindl_r   <= MINDL_RST;
      gdly_r    <= GDLY_RST;
      tmask_r   <= '0;
      tmode_r   <= MODE_BUF;
      leng_r    <= '0;
      acc_r     <= '0;
      busy_r    <= '0;
      emode_r   <= '0;
      bmode_r   <= '0;
      ecode_r   <= ERR_NONE;
      err_r     <= 1'b0;
      accchg_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
      for (int e = 0; e < NENG; e++)
      begin
        emask_r[e] <= '0;
        estrm_r[e] <= '0;
      end
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      mindl_r   <= mindl_nxt;
      gdly_r    <= gdly_nxt;
      tmask_r   <= tmask_nxt;
      tmode_r   <= tmode_nxt;
      leng_r    <= leng_nxt;
      acc_r     <= acc_nxt;
      busy_r    <= busy_nxt;
      emode_r   <= emode_nxt;
      bmode_r   <= bmode_nxt;
      ecode_r   <= ecode_nxt;
      err_r     <= err_nxt;
      accchg_r  <= accchg_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      emask_r   <= emask_nxt;
      estrm_r   <= estrm_nxt;
    end
  end

  assign prdata        = prdata_r;
  assign pslverr       = pslverr_r;
  assign eng_busy      = busy_r;
  assign adc_bank_mode = bmode_r;
  assign acc_pwr_en    = acc_r[0];
  assign acc_clk_out   = acc_r[1];
  assign acc_data_out  = acc_r[2];
  assign acc_data_oe_n = ~acc_r[3];

  // Sync and start sequencing, oversample divider
  asa_state_t st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [23:0] since_r, since_nxt, run_r, run_nxt;
  logic        tarmd_r, tarmd_nxt, rst_r, rst_nxt, go_r, go_nxt, dr_r, dr_nxt;
  logic        osclk_r, osclk_nxt, tick;
  logic [15:0] oscnt_r, oscnt_nxt;
  logic [NTRIG-1:0] drv_r, drv_nxt;
  logic [2:0]  sline, tline;
  assign sline = ctrl_r[CF_SLINE +: 3];
  assign tline = ctrl_r[CF_TLINE +: 3];
  // Free-running timebase ticks every cycle when not locked
  assign tick  = ctrl_r[CB_REFSEL] ? rise[PREF] : 1'b1;

  always_comb
  begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    rst_nxt   = 1'b0;
    go_nxt    = 1'b0;
    tarmd_nxt = tarmd_r | tarm_p;
    since_nxt = &since_r ? since_r : since_r + 24'd1;
    run_nxt   = &run_r ? run_r : run_r + 24'd1;
    unique case (st_r)
      ST_IDLE:
        if (sarm_p)
        begin
          st_nxt  = ctrl_r[CB_SMAST] ? ST_SPULSE : ST_SWAIT;
          rst_nxt = ctrl_r[CB_SMAST];
          cnt_nxt = '0;
        end
      ST_SWAIT:
        if (rise[sline])
        begin
          st_nxt  = ST_SETTLE;
          rst_nxt = 1'b1;
        end
      ST_SPULSE:
      begin
        cnt_nxt = cnt_r + 4'd1;
        if (cnt_r == 4'(SYNC_PULSE_CYC - 1))
          st_nxt = ST_SETTLE;
      end
      ST_SETTLE:
        if (since_r >= gdly_r)
          st_nxt = ST_TWAIT;
      ST_TWAIT:
        if (tarmd_r && ctrl_r[CB_TMAST] && since_r >= mindl_r)
        begin
          st_nxt  = ST_TPULSE;
          go_nxt  = 1'b1;
          cnt_nxt = '0;
        end
        else if (tarmd_r && !ctrl_r[CB_TMAST] && rise[tline])
        begin
          st_nxt = ST_RUN;
          go_nxt = 1'b1;
        end
      ST_TPULSE:
      begin
        cnt_nxt = cnt_r + 4'd1;
        if (cnt_r == 4'(SYNC_PULSE_CYC - 1))
          st_nxt = ST_RUN;
      end
      ST_RUN: ;
    endcase
    if (rst_nxt)
      since_nxt = '0;
    if (go_nxt)
    begin
      run_nxt   = '0;
      tarmd_nxt = 1'b0;
    end
    if (stop_p)
    begin
      st_nxt    = ST_IDLE;
      tarmd_nxt = 1'b0;
    end
    // Samples show only once the filter has flushed
    dr_nxt  = st_nxt == ST_RUN && st_r == ST_RUN && run_r >= gdly_r;
    drv_nxt = '0;
    if (st_nxt == ST_SPULSE)
      drv_nxt[sline] = 1'b1;
    else if (st_nxt == ST_TPULSE)
      drv_nxt[tline] = 1'b1;
    oscnt_nxt = oscnt_r;
    osclk_nxt = osclk_r;
    if (rst_nxt)
    begin
      oscnt_nxt = '0;
      osclk_nxt = 1'b0;
    end
    else if (tick)
    begin
      oscnt_nxt = oscnt_r == 16'(OS_DIV / 2 - 1) ? 16'h0 : oscnt_r + 16'h1;
      if (oscnt_r == 16'(OS_DIV / 2 - 1))
        osclk_nxt = ~osclk_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r    <= ST_IDLE;
      cnt_r   <= '0;
      since_r <= '0;
      run_r   <= '0;
      tarmd_r <= 1'b0;
      rst_r   <= 1'b0;
      go_r    <= 1'b0;
      dr_r    <= 1'b0;
      drv_r   <= '0;
      oscnt_r <= '0;
      osclk_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      since_r <= since_nxt;
      run_r   <= run_nxt;
      tarmd_r <= tarmd_nxt;
      rst_r   <= rst_nxt;
      go_r    <= go_nxt;
      dr_r    <= dr_nxt;
      drv_r   <= drv_nxt;
      oscnt_r <= oscnt_nxt;
      osclk_r <= osclk_nxt;
    end
  end

  assign adc_sync_rst = rst_r;
  assign acq_start    = go_r;
  assign data_ready   = dr_r;
  assign trig_out     = drv_r;
  assign trig_oe_n    = ~drv_r;
  assign os_clk_out   = osclk_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_master_arm;
    st_r == ST_IDLE && sarm_p && ctrl_r[CB_SMAST];
  endsequence
  a_sync_pulse_width: assert property (s_master_arm |=> (trig_oe_n[sline] == 1'b0) [*8]
    ##1 trig_oe_n[sline]) else $error("sync pulse width wrong");
  a_slave_sync_rst: assert property (st_r == ST_SWAIT && rise[sline] |=> adc_sync_rst
    && oscnt_r == 16'h0) else $error("slave missed sync reset");
  a_start_gated: assert property (acq_start |-> $past(since_r) >= gdly_r)
    else $error("start before group delay");
  a_data_delay: assert property ($rose(data_ready) |-> run_r > gdly_r)
    else $error("data shown before group delay");
  a_chan_refuse: assert property (alloc_p && !free_p && (tmask_r & cbusy) != 0 && eng_free |=>
    err_r && ecode_r == ERR_CHAN && busy_r == $past(busy_r))
    else $error("double allocation accepted");
  a_engine_full: assert property (alloc_p && pc != '0 && busy_r == 4'hF && !free_p |=>
    busy_r == 4'hF && ecode_r == ERR_ENGINE) else $error("fifth task accepted");
  a_mode_conflict: assert property (alloc_p && rej == ERR_MODE |=> err_r
    && bmode_r == $past(bmode_r)) else $error("bank mode conflict accepted");
  a_stream_limit: assert property (used_buf <= 3'd4 && used_hw <= 3'd4)
    else $error("stream count exceeded");
  a_bank_forced: assert property (alloc_p && rej == ERR_NONE && tmask_r[7:0] != 0
    |=> bmode_r[0] == $past(cmode)) else $error("bank mode not forced");
endmodule : asa_sync_alloc
`default_nettype wire

// *** testbench/asa_peer.sv ***
// Backplane peer: reference clock source and trigger line driver
`timescale 1ns/1ps
`default_nettype none
module asa_peer
  import asa_pkg::*;
#(
  parameter int PULSE_NS = 80
) (
  // Backplane reference clock
  output logic                      ref_clk,
  // Trigger line drive, released lines fall to the pull-down
  output logic [asa_pkg::NTRIG-1:0] drv,
  output logic [asa_pkg::NTRIG-1:0] drv_en
);
  // Odd offset keeps the reference unrelated in phase to clk
  initial
  begin
    ref_clk = 1'b0;
    drv = '0;
    drv_en = '0;
    #13;
    forever #40 ref_clk = ~ref_clk;
  end

  // Single pulse on one line, as a sync or start master would send
  task automatic pulse(input int line);
    drv_en[line] <= 1'b1;
    drv[line] <= 1'b1;
    #PULSE_NS;
    drv[line] <= 1'b0;
    drv_en[line] <= 1'b0;
  endtask : pulse
endmodule : asa_peer
`default_nettype wire

// *** testbench/acquisition_sync_and_stream_allocator_tb.sv ***
// Testbench for the sync and stream allocator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL %0t mismatch got %0h exp %0h", $time, (a), (b)); end end
module acquisition_sync_and_stream_allocator_tb;
  import asa_pkg::*;
  typedef struct packed {
    logic [31:0] mask; logic [7:0] cmd; logic [2:0] code;
    logic [3:0]  busy; logic [3:0] bm;  logic [31:0] cb;
  } asa_row_t;
  localparam int GD_M = 8;
  localparam int GD_S = 40;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, ref_clk;
  logic [7:0]  paddr, trig_out, trig_oe_n, peer_drv, peer_en, trig_line;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  adc_bank_mode, eng_busy;
  logic        adc_sync_rst, os_clk_out, acq_start, data_ready, prev, last_err;
  logic        acc_detect_n, acc_data_in, acc_pwr_en, acc_clk_out, acc_data_out;
  logic        acc_data_oe_n;
  int          error_cnt, tests_run, cyc, n, k;
  asa_row_t    rows [15];

  // Released lines read low; no line is driven by two parties here
  assign trig_line = (~trig_oe_n & trig_out) | (trig_oe_n & peer_en & peer_drv);

  asa_sync_alloc #(.OS_DIV(4)) i_dut (
    .clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clk_in(ref_clk), .trig_in(trig_line),
    .trig_out(trig_out), .trig_oe_n(trig_oe_n), .adc_sync_rst(adc_sync_rst),
    .os_clk_out(os_clk_out), .adc_bank_mode(adc_bank_mode), .acq_start(acq_start),
    .data_ready(data_ready), .eng_busy(eng_busy), .acc_detect_n(acc_detect_n),
    .acc_data_in(acc_data_in), .acc_pwr_en(acc_pwr_en), .acc_clk_out(acc_clk_out),
    .acc_data_out(acc_data_out), .acc_data_oe_n(acc_data_oe_n));
  asa_peer i_peer (.ref_clk(ref_clk), .drv(peer_drv), .drv_en(peer_en));

  always #5 clk = ~clk;

  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rdv);
    int m;
    m = 0;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && m < 100)
    begin
      m++;
      @(posedge clk);
    end
    if (m == 100)
      error_cnt++;
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    apb(a, 1'b1, v, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    apb(a, 1'b0, 32'h0, v);
  endtask : rd

  initial
  begin
    rows = '{
      '{32'h0000_0001, 8'h02, 3'h0, 4'h1, 4'h0, 32'h0000_0001},
      '{32'h0000_0002, 8'h03, 3'h4, 4'h1, 4'h0, 32'h0000_0001},
      '{32'h0000_0001, 8'h02, 3'h3, 4'h1, 4'h0, 32'h0000_0001},
      '{32'h0000_0000, 8'h02, 3'h1, 4'h1, 4'h0, 32'h0000_0001},
      '{32'h0000_0100, 8'h03, 3'h0, 4'h3, 4'h2, 32'h0000_0101},
      '{32'h0001_0000, 8'h02, 3'h0, 4'h7, 4'h2, 32'h0001_0101},
      '{32'h0100_0000, 8'h02, 3'h0, 4'hF, 4'h2, 32'h0101_0101},
      '{32'h0000_0002, 8'h02, 3'h2, 4'hF, 4'h2, 32'h0101_0101},
      '{32'h0000_0000, 8'h04, 3'h0, 4'hE, 4'h0, 32'h0000_0000},
      '{32'h0000_0000, 8'h14, 3'h0, 4'hC, 4'h0, 32'h0000_0000},
      '{32'h0000_0000, 8'h24, 3'h0, 4'h8, 4'h0, 32'h0000_0000},
      '{32'h0000_0000, 8'h34, 3'h0, 4'h0, 4'h0, 32'h0000_0000},
      '{32'h01FF_FFFF, 8'h02, 3'h0, 4'h1, 4'h0, 32'h01FF_FFFF},
      '{32'h0200_0000, 8'h02, 3'h5, 4'h1, 4'h0, 32'h01FF_FFFF},
      '{32'h0200_0000, 8'h03, 3'h4, 4'h1, 4'h0, 32'h01FF_FFFF}};
    clk = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    acc_detect_n = 1'b1;
    acc_data_in = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    `CHK(trig_oe_n, 8'hFF)
    rd(OFS_CTRL, d);
    `CHK(d, 32'h0000_0001)
    rd(OFS_GDLY, d);
    `CHK(d, 32'h0000_0400)
    rd(OFS_MINDL, d);
    `CHK(d, 32'h0000_0000)
    rd(8'h24, d);
    `CHK({last_err, d}, {1'b1, 32'h0})
    // Oversample clock follows the 80 ns reference, one toggle per two edges
    n = 0;
    prev = os_clk_out;
    repeat (200)
    begin
      @(negedge clk);
      if (os_clk_out !== prev)
        n++;
      prev = os_clk_out;
    end
    `CHK(n >= 11 && n <= 14, 1'b1)
    foreach (rows[i])
    begin
      wr(OFS_STAT, 32'h0000_2010);
      wr(OFS_TMASK, rows[i].mask);
      wr(OFS_TCMD, {24'h0, rows[i].cmd});
      rd(OFS_STAT, d);
      `CHK(d[SB_ERR], rows[i].code != 3'h0)
      if (rows[i].code != 3'h0)
        `CHK(d[SF_ECODE+:3], rows[i].code)
      `CHK(eng_busy, rows[i].busy)
      if (rows[i].cmd[TB_ALLOC])
      begin
        `CHK(adc_bank_mode, rows[i].bm)
        rd(OFS_CBUSY, d);
        `CHK(d, rows[i].cb)
      end
    end
    rd(OFS_ALLOC, d);
    `CHK(d[14:12], 3'h4)
    // Reset in mid-run must drop every allocation
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    `CHK(eng_busy, 4'h0)
    // Master: sync on line 2, start on line 5
    wr(OFS_GDLY, GD_M);
    wr(OFS_MINDL, 32'h0000_003C);
    wr(OFS_CTRL, 32'h0000_5207);
    wr(OFS_CTRL, 32'h0000_520F);
    @(negedge clk);
    `CHK(adc_sync_rst, 1'b1)
    `CHK(trig_oe_n, 8'hFB)
    `CHK(trig_out[2], 1'b1)
    @(negedge clk);
    `CHK(adc_sync_rst, 1'b0)
    n = 2;
    while (trig_oe_n[2] === 1'b0 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n, SYNC_PULSE_CYC + 1)
    repeat (GD_M + 4) @(posedge clk);
    wr(OFS_CTRL, 32'h0000_5217);
    n = 0;
    while (acq_start !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(acq_start, 1'b1)
    // Start held back until 60 cycles after sync, armed 23 after it
    `CHK(n >= 36 && n <= 40, 1'b1)
    @(negedge clk);
    `CHK(trig_oe_n, 8'hDF)
    n = 1;
    while (data_ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= GD_M && n <= GD_M + 3, 1'b1)
    wr(OFS_CTRL, 32'h0000_0021);
    @(negedge clk);
    `CHK(data_ready, 1'b0)
    // Slave: sync from line 3, start from line 6; early start edge is lost
    wr(OFS_GDLY, GD_S);
    wr(OFS_CTRL, 32'h0000_6309);
    fork
      i_peer.pulse(3);
    join_none
    n = 0;
    while (adc_sync_rst !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(adc_sync_rst, 1'b1)
    `CHK(trig_oe_n, 8'hFF)
    // Armed for start, yet the edge during settling must be ignored
    wr(OFS_CTRL, 32'h0000_6311);
    fork
      i_peer.pulse(6);
    join_none
    k = 0;
    repeat (GD_S + 4)
    begin
      @(negedge clk);
      if (acq_start === 1'b1)
        k++;
    end
    `CHK(k, 0)
    fork
      i_peer.pulse(6);
    join_none
    n = 0;
    while (acq_start !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(acq_start, 1'b1)
    wr(OFS_CTRL, 32'h0000_0021);
    // Accessory insert, pin drive and serial input
    acc_detect_n <= 1'b0;
    acc_data_in <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFS_STAT, d);
    `CHK(d[13:12], 2'h3)
    wr(OFS_ACC, 32'h0000_000F);
    @(negedge clk);
    `CHK({acc_data_oe_n, acc_data_out, acc_clk_out, acc_pwr_en}, 4'h7)
    rd(OFS_ACC, d);
    `CHK(d[5:4], 2'h3)
    // Free-running timebase: a tick every cycle, toggle every two
    wr(OFS_CTRL, 32'h0000_0000);
    n = 0;
    prev = os_clk_out;
    repeat (40)
    begin
      @(negedge clk);
      if (os_clk_out !== prev)
        n++;
      prev = os_clk_out;
    end
    `CHK(n >= 19 && n <= 21, 1'b1)
    final_report();
  end
endmodule : acquisition_sync_and_stream_allocator_tb
`default_nettype wire
